// ==== rtl/dsp_pkg.sv ====
// constants, types and register map of the dual-slope pwm compare unit
//
// Overview of operation
// - selector 1 or 5 runs the counter up to top and back down.
// - dual-slope top is 0xff for selector 1, compare value a for 5.
// - at top the direction reverses; top is held for one tick.
// - non-inverting clears on up match, sets on down match; inverting opposite.
// - action selector two gives non-inverted pwm, three inverted pwm.
// - dual-slope overflow flag sets when the counter reaches zero on the down slope.
// - compare zero keeps output low, maximum keeps it high (non-inverted).
// - leaving compare maximum keeps the down-slope result at that top; the old value still matches there.
// - a missed up match still produces its output change.
// - counter compared with both values; equality sets match flag next tick.
// - match flag requests interrupt if enabled; cleared by service or one.
// - compare values double buffered in pwm modes, direct otherwise.
// - software reaches the buffer when buffered, else the active value.
// - force strobe updates output in non-pwm modes, no flag, no reload.
// - a counter write blocks flag and output matches, not the ctc clear, for the next tick, even stopped.
// - compare output bit keeps its value across mode changes.
// - action selector bits are not buffered and act at once.
// - nonzero action selector overrides port data; direction stays with port.
// - action selector 0 disconnects the waveform generator.
// - selector 0 free runs upward and wraps from maximum to zero.
// - selector 2 clears the counter on a match with compare value a.
// - clock source zero stops counting; the counter stays accessible.
package dsp_pkg;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_COUNTER_VALUE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_COMPARE_VALUE_A = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_COMPARE_VALUE_B = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_FORCE = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h1c;

	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_STEP = 8'h01;
	localparam logic [2:0] CS_STOPPED = 3'h0;

	// flag register bit positions
	localparam int FLAG_OVERFLOW = 0;
	localparam int FLAG_MATCH_A = 1;
	localparam int FLAG_MATCH_B = 2;
	localparam int NUM_FLAGS = 3;
	localparam int NUM_CH = 2;
	// port register: data bits then direction bits
	localparam int PORT_OUT_LSB = 0;
	localparam int PORT_DIR_LSB = 2;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_PC_FULL = 3'b001,
		MODE_CTC = 3'b010,
		MODE_FAST_FULL = 3'b011,
		MODE_RSVD4 = 3'b100,
		MODE_PC_CMPA = 3'b101,
		MODE_RSVD6 = 3'b110,
		MODE_FAST_CMPA = 3'b111
	} dsp_mode_t;

	typedef enum logic [1:0] {
		ACT_OFF = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR = 2'b10,
		ACT_SET = 2'b11
	} dsp_action_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} dsp_dir_t;

	// control register layout, bits 31:11 and 3 reserved
	typedef struct packed {
		logic [20:0] rsvd_hi;
		logic [2:0] clock_source_sel;
		dsp_action_t output_action_sel_b;
		dsp_action_t output_action_sel_a;
		logic rsvd_lo;
		dsp_mode_t waveform_mode_sel;
	} dsp_ctrl_t;

	localparam dsp_ctrl_t CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_07f7;

	typedef struct packed {
		logic [NUM_CH-1:0] out;
		logic [NUM_CH-1:0] oe_n;
	} dsp_pins_t;

endpackage

// ==== rtl/dsp_pwm_unit.sv ====
// dual-slope pwm timer with two compare channels behind an apb slave
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_unit import dsp_pkg::*; (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer tick from the prescaler, same clock domain
	input wire logic timer_tick,
	// interrupt controller: overflow, match a, match b
	input wire logic [NUM_FLAGS-1:0] irq_serviced,
	output logic [NUM_FLAGS-1:0] irq_request,
	// compare pins
	output var dsp_pins_t compare_pins
);

	function automatic logic is_pc(input dsp_mode_t m);
		is_pc = (m == MODE_PC_FULL) || (m == MODE_PC_CMPA);
	endfunction

	function automatic logic is_fast(input dsp_mode_t m);
		is_fast = (m == MODE_FAST_FULL) || (m == MODE_FAST_CMPA);
	endfunction

	function automatic logic top_is_cmpa(input dsp_mode_t m);
		top_is_cmpa = (m == MODE_PC_CMPA) || (m == MODE_FAST_CMPA) || (m == MODE_CTC);
	endfunction

	// output action outside the pwm modes
	function automatic logic non_pwm_action(input dsp_action_t a, input logic cur);
		case (a)
			ACT_TOGGLE: non_pwm_action = ~cur;
			ACT_CLEAR: non_pwm_action = 1'b0;
			ACT_SET: non_pwm_action = 1'b1;
			default: non_pwm_action = cur;
		endcase
	endfunction

	// dual-slope level: up-slope result clears, down-slope sets; set selector inverts
	function automatic logic slope_result(input logic down, input dsp_action_t a);
		slope_result = down ^ (a == ACT_SET);
	endfunction

	// state
	dsp_ctrl_t ctrl;
	logic [7:0] counter_value;
	dsp_dir_t dir;
	logic [7:0] compare_value [NUM_CH];
	logic [7:0] compare_buffer [NUM_CH];
	logic [NUM_FLAGS-1:0] flags;
	logic [NUM_FLAGS-1:0] irq_enable;
	logic [NUM_CH-1:0] port_out;
	logic [NUM_CH-1:0] port_dir;
	logic [NUM_CH-1:0] compare_output_bit;
	logic match_block;

	// bus decode
	wire logic setup_phase = psel & ~penable;
	wire logic access_phase = psel & penable;
	wire logic bus_wr = access_phase & pwrite;
	wire logic sel_control = paddr == ADDR_CONTROL;
	wire logic sel_counter = paddr == ADDR_COUNTER_VALUE;
	wire logic sel_cmp_a = paddr == ADDR_COMPARE_VALUE_A;
	wire logic sel_cmp_b = paddr == ADDR_COMPARE_VALUE_B;
	wire logic sel_flags = paddr == ADDR_FLAGS;
	wire logic sel_force = paddr == ADDR_FORCE;
	wire logic sel_port = paddr == ADDR_PORT;
	wire logic sel_irq_en = paddr == ADDR_IRQ_ENABLE;
	wire logic mapped = sel_control | sel_counter | sel_cmp_a | sel_cmp_b |
		sel_flags | sel_force | sel_port | sel_irq_en;
	wire logic [NUM_CH-1:0] wr_cmp = {NUM_CH{bus_wr}} & {sel_cmp_b, sel_cmp_a};
	wire logic wr_counter = bus_wr & sel_counter;

	// mode decode
	wire dsp_mode_t mode = ctrl.waveform_mode_sel;
	wire logic pc_mode = is_pc(mode);
	wire logic fast_mode = is_fast(mode);
	wire logic pwm_mode = pc_mode | fast_mode;
	wire logic ctc_mode = mode == MODE_CTC;
	wire dsp_action_t action [NUM_CH];
	assign action[0] = ctrl.output_action_sel_a;
	assign action[1] = ctrl.output_action_sel_b;

	// stopped clock source freezes counting, match and overflow flags, tick-driven outputs and buffer loads
	wire logic tick = timer_tick & (ctrl.clock_source_sel != CS_STOPPED);

	wire logic [7:0] top_value = top_is_cmpa(mode) ? compare_value[0] : CNT_MAX;
	wire logic at_top = counter_value == top_value;
	wire logic at_bottom = counter_value == CNT_BOTTOM;
	wire logic [7:0] count_up = counter_value + CNT_STEP;
	wire logic [7:0] count_down = counter_value - CNT_STEP;

	// raw equality and the blocked match that drives flags and outputs
	logic [NUM_CH-1:0] equal;
	logic [NUM_CH-1:0] match;
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			equal[i] = counter_value == compare_value[i];
			match[i] = equal[i] & ~match_block;
		end
	end

	// at top the match counts as a down-slope match, at bottom as up-slope
	wire logic eff_down = pc_mode & (((dir == DIR_DOWN) & ~at_bottom) | at_top);

	// counting sequence
	// limitation: a count written above a compare-a top while counting up rises to the maximum and wraps first
	logic [7:0] next_counter;
	dsp_dir_t next_dir;
	always_comb begin
		next_counter = count_up;
		next_dir = DIR_UP;
		if (pc_mode) begin
			next_dir = dir;
			if (dir == DIR_UP) begin
				if (at_top) begin
					// top already held for this tick, turn round now
					next_dir = DIR_DOWN;
					next_counter = at_bottom ? counter_value : count_down;
				end
			end else begin
				if (at_bottom) begin
					next_dir = DIR_UP;
					next_counter = at_top ? counter_value : count_up;
				end else begin
					next_counter = count_down;
				end
			end
		end else if (ctc_mode && equal[0]) begin
			next_counter = CNT_BOTTOM;
		end else if (fast_mode && at_top) begin
			next_counter = CNT_BOTTOM;
		end
		// normal mode simply wraps through count_up
	end

	// overflow event per mode
	logic overflow_event;
	always_comb begin
		if (pc_mode) begin
			overflow_event = tick & at_bottom & (dir == DIR_DOWN);
		end else if (fast_mode) begin
			overflow_event = tick & at_top;
		end else begin
			overflow_event = tick & (counter_value == CNT_MAX) & ~(ctc_mode & equal[0]);
		end
	end

	// buffered compare values move into the active registers at top
	wire logic buffer_update = pwm_mode & tick & at_top;

	wire logic [NUM_CH-1:0] force_hit = {NUM_CH{bus_wr & sel_force & ~pwm_mode}} & pwdata[NUM_CH-1:0];

	// waveform generator
	logic [NUM_CH-1:0] next_output_bit;
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_output_bit[i] = compare_output_bit[i];
			if (action[i] == ACT_OFF) begin
				next_output_bit[i] = compare_output_bit[i];
			end else if (!pwm_mode) begin
				if (force_hit[i] || (tick && match[i])) begin
					next_output_bit[i] = non_pwm_action(action[i], compare_output_bit[i]);
				end
			end else if (tick) begin
				if (action[i] == ACT_TOGGLE) begin
					if (match[i]) begin
						next_output_bit[i] = ~compare_output_bit[i];
					end
				end else if (pc_mode) begin
					// set selector means inverted: up match sets, down match clears
					if (match[i]) begin
						next_output_bit[i] = slope_result(eff_down, action[i]);
					end else if (at_top) begin
						// missed or vanished up match, keep the period symmetric
						next_output_bit[i] = slope_result(1'b0, action[i]);
					end else if (at_bottom) begin
						next_output_bit[i] = slope_result(1'b1, action[i]);
					end
				end else begin
					// fast pwm: bottom reload wins so a maximum compare stays constant
					if (at_top) begin
						next_output_bit[i] = action[i] != ACT_SET;
					end else if (match[i]) begin
						next_output_bit[i] = action[i] == ACT_SET;
					end
				end
			end
		end
	end

	// flags: hardware set beats a clear in the same cycle
	logic [NUM_FLAGS-1:0] flag_set;
	logic [NUM_FLAGS-1:0] flag_clear;
	always_comb begin
		flag_set = '0;
		flag_set[FLAG_OVERFLOW] = overflow_event;
		flag_set[FLAG_MATCH_A] = tick & match[0];
		flag_set[FLAG_MATCH_B] = tick & match[1];
		flag_clear = irq_serviced;
		if (bus_wr && sel_flags) begin
			flag_clear = flag_clear | pwdata[NUM_FLAGS-1:0];
		end
	end
	wire logic [NUM_FLAGS-1:0] next_flags = (flags & ~flag_clear) | flag_set;

	// read selection; compare reads follow the write target
	wire logic [7:0] rd_cmp_a = pwm_mode ? compare_buffer[0] : compare_value[0];
	wire logic [7:0] rd_cmp_b = pwm_mode ? compare_buffer[1] : compare_value[1];
	wire logic [31:0] rd_data =
		sel_control ? (ctrl & CTRL_WMASK) :
		sel_counter ? {24'h00_0000, counter_value} :
		sel_cmp_a ? {24'h00_0000, rd_cmp_a} :
		sel_cmp_b ? {24'h00_0000, rd_cmp_b} :
		sel_flags ? {29'h0000_0000, flags} :
		sel_port ? {28'h000_0000, port_dir, port_out} :
		sel_irq_en ? {29'h0000_0000, irq_enable} :
		32'h0000_0000;

	// zero wait states: data is captured in the setup phase
	assign pready = 1'b1;
	assign pslverr = access_phase & ~mapped;
	assign irq_request = flags & irq_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= rd_data;
		end
	end

	// control, port and enable registers; action bits act at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			port_out <= '0;
			port_dir <= '0;
			irq_enable <= '0;
		end else if (bus_wr) begin
			if (sel_control) begin
				ctrl <= pwdata & CTRL_WMASK;
			end
			if (sel_port) begin
				port_out <= pwdata[PORT_OUT_LSB +: NUM_CH];
				port_dir <= pwdata[PORT_DIR_LSB +: NUM_CH];
			end
			if (sel_irq_en) begin
				irq_enable <= pwdata[NUM_FLAGS-1:0];
			end
		end
	end

	// counter: a bus write beats counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value <= CNT_BOTTOM;
			dir <= DIR_UP;
		end else if (wr_counter) begin
			counter_value <= pwdata[7:0];
		end else if (tick) begin
			counter_value <= next_counter;
			dir <= next_dir;
		end
	end

	// the block survives a stopped clock until the next real tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_block <= 1'b0;
		end else if (wr_counter) begin
			match_block <= 1'b1;
		end else if (tick) begin
			match_block <= 1'b0;
		end
	end

	// active compare values: direct writes outside pwm, buffer copy at top inside
	logic [7:0] next_compare_value [NUM_CH];
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_compare_value[i] = compare_value[i];
			if (wr_cmp[i] && !pwm_mode) begin
				next_compare_value[i] = pwdata[7:0];
			end else if (buffer_update) begin
				next_compare_value[i] = compare_buffer[i];
			end
		end
	end

	// compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				compare_value[i] <= CNT_BOTTOM;
				compare_buffer[i] <= CNT_BOTTOM;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_cmp[i]) begin
					compare_buffer[i] <= pwdata[7:0];
				end
				compare_value[i] <= next_compare_value[i];
			end
		end
	end

	// flags and the compare output bits, which no mode change touches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
			compare_output_bit <= '0;
		end else begin
			flags <= next_flags;
			compare_output_bit <= next_output_bit;
		end
	end

	// pin override; direction always from the port register
	dsp_pins_t next_pins;
	always_comb begin
		next_pins.oe_n = ~port_dir;
		for (int i = 0; i < NUM_CH; i++) begin
			next_pins.out[i] = (action[i] != ACT_OFF) ? compare_output_bit[i] : port_out[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_pins <= '{out: '0, oe_n: '1};
		end else begin
			compare_pins <= next_pins;
		end
	end

endmodule

`default_nettype wire

// ==== tb/dsp_pwm_unit_checker.sv ====
// port assertions for the dsp pwm unit
`timescale 1ns/1ps
`default_nettype none
module dsp_pwm_checker import dsp_pkg::*; (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	// timer, interrupts, pins
	input wire logic timer_tick,
	input wire logic [NUM_FLAGS-1:0] irq_serviced,
	input wire logic [NUM_FLAGS-1:0] irq_request,
	input wire dsp_pins_t compare_pins
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadows of writable registers, taken on the unit's own write edge
	logic [31:0] ctrl_q;
	logic [31:0] port_q;
	logic [2:0] en_q;
	wire wr = psel && penable && pwrite;
	wire wr_ctrl = wr && paddr == ADDR_CONTROL;
	wire wr_force = wr && paddr == ADDR_FORCE;
	wire wr_flag = wr && paddr == ADDR_FLAGS;
	wire [1:0] act_a = ctrl_q[5:4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
			port_q <= '0;
			en_q <= '0;
		end else if (wr) begin
			if (paddr == ADDR_CONTROL)
				ctrl_q <= pwdata & CTRL_WMASK;
			if (paddr == ADDR_PORT)
				port_q <= pwdata;
			if (paddr == ADDR_IRQ_ENABLE)
				en_q <= pwdata[2:0];
		end
	end
	property p_dir;
		compare_pins.oe_n == ~$past(port_q[3:2]);
	endproperty
	a_dir: assert property (p_dir) else $error("pin enable not from direction bits");
	property p_data;
		$past(act_a) == 2'b00 |-> compare_pins.out[0] == $past(port_q[0]);
	endproperty
	a_data: assert property (p_data) else $error("disconnected pin not port data");
	// an overridden pin may only move after a tick, a force or a control write
	property p_hold;
		act_a != 2'b00 && !timer_tick && !wr_force && !wr_ctrl |=> ##1 $stable(compare_pins.out[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("overridden pin moved without cause");
	property p_force;
		wr_force && pwdata[0] && !ctrl_q[0] && act_a[1] |-> ##2 compare_pins.out[0] == $past(act_a[0], 2);
	endproperty
	a_force: assert property (p_force) else $error("force did not apply action");
	property p_irq;
		(irq_request & ~en_q) == 3'b000;
	endproperty
	a_irq: assert property (p_irq) else $error("request while disabled");
	property p_swclr;
		wr_flag && pwdata[1] && !timer_tick |=> !irq_request[1];
	endproperty
	a_swclr: assert property (p_swclr) else $error("flag not cleared by write");
	property p_svc;
		irq_serviced[0] && !timer_tick |=> !irq_request[0];
	endproperty
	a_svc: assert property (p_svc) else $error("flag not cleared by service");
	property p_tick;
		$rose(irq_request[2]) && $past(en_q[2]) |-> $past(timer_tick) && $past(ctrl_q[10:8]) != CS_STOPPED;
	endproperty
	a_tick: assert property (p_tick) else $error("match flag set without tick");
	c_force: cover property (wr_force && act_a == 2'b11);
	c_match: cover property ($rose(irq_request[2]));
	c_pc5: cover property (ctrl_q[2:0] == 3'd5 && timer_tick);
endmodule
bind dsp_pwm_unit dsp_pwm_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .timer_tick(timer_tick), .irq_serviced(irq_serviced),
	.irq_request(irq_request), .compare_pins(compare_pins));
`default_nettype wire

// ==== tb/dsp_pin_model.sv ====
// port pads with pull-downs, driven by the unit when enabled
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_model import dsp_pkg::*; (
	// pins from the unit
	input wire dsp_pins_t pins,
	// resolved pad levels
	output logic [NUM_CH-1:0] level
);
	// an undriven pad falls to its pull-down, never the last value
	assign level = pins.out & ~pins.oe_n;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the dsp pwm unit
`timescale 1ns/1ps
`default_nettype none
module tb_top import dsp_pkg::*; ;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_tick = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic pready, pslverr, rerr, run = 1'b0;
	logic [NUM_FLAGS-1:0] irq_serviced = '0, irq_request, flg;
	dsp_pins_t compare_pins;
	logic [NUM_CH-1:0] level;
	int fails = 0, tests_run = 0;
	int cnt, up, bit_m, pin_m, top, m, mode, inv, ca, cb;
	int s_mode[4] = '{1, 1, 1, 5};
	int s_act[4] = '{3, 2, 2, 2};
	int s_cb[4] = '{-1, 255, 0, -1};
	always #2 pclk = ~pclk;
	dsp_pwm_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_tick(timer_tick), .irq_serviced(irq_serviced), .irq_request(irq_request),
		.compare_pins(compare_pins));
	dsp_pin_model i_pins (.pins(compare_pins), .level(level));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100)
			fails++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic summarize();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// service pulses only while the model runs, so flag reads elsewhere stay exact
	always @(posedge pclk) begin
		timer_tick <= ($urandom % 4) != 0;
		irq_serviced <= (run && $urandom % 8 == 0) ? 3'($urandom) : 3'b000;
	end
	// reference model: channel b pin, counter and flags, one pclk pin lag
	always @(posedge pclk) begin
		if (run) begin
			check(level[1], pin_m);
			check(irq_request, flg);
			pin_m = bit_m;
			flg = flg & ~irq_serviced;
			if (timer_tick) begin
				top = (mode == 5) ? ca : 255;
				m = (cnt == cb);
				if (cnt == ca)
					flg[1] = 1'b1;
				if (m)
					flg[2] = 1'b1;
				if (cnt == top) begin
					bit_m = m ? !inv : inv;
					up = 0;
					cnt = cnt - 1;
				end else if (cnt == 0) begin
					bit_m = m ? inv : !inv;
					if (!up)
						flg[0] = 1'b1;
					up = 1;
					cnt = 1;
				end else begin
					if (m)
						bit_m = up ? inv : !inv;
					cnt = up ? cnt + 1 : cnt - 1;
				end
			end
		end
	end
	// whole run is under 8000 cycles
	initial begin
		#100000;
		fails++;
		summarize();
	end
	initial begin
		void'($urandom(32'h434192a3));
		reset_dut();
		for (int a = 0; a < 32; a += 4) begin
			apb(1'b0, 8'(a), '0);
			check(rdat, 32'h0);
		end
		apb(1'b0, 8'h20, '0);
		check(rerr, 1'b1);
		$display("test reset values done");
		wr(ADDR_PORT, 32'h4);
		for (int k = 3; k >= 1; k--) begin
			wr(ADDR_CONTROL, 32'(k) << 4);
			wr(ADDR_FORCE, 32'h1);
			repeat (2) @(posedge pclk);
			check(level[0], k != 2);
		end
		apb(1'b0, ADDR_FLAGS, '0);
		check(rdat, 32'h0);
		$display("test force done");
		wr(ADDR_COMPARE_VALUE_A, 32'h5);
		wr(ADDR_COUNTER_VALUE, 32'h5);
		wr(ADDR_CONTROL, 32'h100);
		repeat (20) @(posedge pclk);
		wr(ADDR_CONTROL, 32'h0);
		apb(1'b0, ADDR_FLAGS, '0);
		check(rdat, 32'h0);
		$display("test counter write block done");
		for (int s = 0; s < 4; s++) begin
			reset_dut();
			mode = s_mode[s];
			inv = s_act[s] & 1;
			ca = (mode == 5) ? 8'h9c : 8'h30;
			cb = (s_cb[s] < 0) ? 1 + $urandom % (((mode == 5) ? ca : 255) - 1) : s_cb[s];
			cnt = 0;
			up = 1;
			bit_m = 0;
			pin_m = 0;
			flg = '0;
			wr(ADDR_COMPARE_VALUE_A, ca);
			wr(ADDR_COMPARE_VALUE_B, cb);
			wr(ADDR_IRQ_ENABLE, 32'h7);
			wr(ADDR_PORT, 32'h8);
			wr(ADDR_CONTROL, (32'(s_act[s]) << 6) | 32'h100 | 32'(mode));
			run <= 1'b1;
			repeat (1500) @(posedge pclk);
			wr(ADDR_CONTROL, 32'h0);
			run <= 1'b0;
			apb(1'b0, ADDR_COUNTER_VALUE, '0);
			check(rdat, cnt);
			wr(ADDR_FLAGS, 32'h7);
			apb(1'b0, ADDR_FLAGS, '0);
			check(rdat, 32'h0);
			$display("test pwm session %0d done", s);
		end
		summarize();
	end
endmodule
`default_nettype wire
